// ==== hdl/device_reset_control.sv ====
// Reset sequencer and register file of the monitor-and-control device
// Functional notes
// - Once every supply rail is up the device raises its own power-on reset event.
// - A power-on reset loads every register with its default value.
// - After a power-on reset the serial port is valid only once 250 us have passed.
// - After reset the device sits in power-down mode set by register 0x02.
// - A low of at least 20 ns on the reset pin starts a hardware reset.
// - A hardware reset restores all defaults and the port is valid 250 us later.
// - Writing a one to the soft reset bit of register 0x00 starts a software reset.
// - A software reset restores all registers except those at 0x00 and 0x01.
// - After a software reset the port is valid only once 100 ns have passed.
module device_reset_control #(
  parameter int POR_CYC = rst_ctl_pkg::POR_DELAY_CYC,
  parameter int HW_CYC  = rst_ctl_pkg::HW_DELAY_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  supplies_ok,
  input  wire logic                  reset_pin_n,
  input  wire rst_ctl_pkg::reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  output logic                       comm_valid,
  output logic [7:0]                 block_enable
);

  rst_ctl_pkg::seq_state_t   st_q;
  rst_ctl_pkg::seq_state_t   st_d;
  rst_ctl_pkg::reset_cause_t cause_q;
  rst_ctl_pkg::reset_cause_t cause_d;
  logic [3:0]                lo_cnt_q;
  logic [3:0]                lo_cnt_d;
  logic                      hw_req;
  logic                      sw_go;
  logic                      wr_ok;
  logic                      tmr_load;
  logic [rst_ctl_pkg::TMR_W-1:0] tmr_cycles;
  logic                      tmr_expired;
  logic [6:0]                icfg0_q;
  logic [6:0]                icfg0_d;
  logic [7:0]                icfg1_q;
  logic [7:0]                icfg1_d;
  logic [7:0]                pd_q;
  logic [7:0]                pd_d;
  logic [7:0]                rdata_q;
  logic [7:0]                rdata_d;
  logic                      valid_q;
  logic                      valid_d;
  logic [7:0]                en_q;
  logic [7:0]                en_d;

  // Register read view; the soft reset bit always reads zero
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      rst_ctl_pkg::ADDR_ICFG0:   r = {1'b0, icfg0_q};
      rst_ctl_pkg::ADDR_ICFG1:   r = icfg1_q;
      rst_ctl_pkg::ADDR_PD_CTRL: r = pd_q;
      rst_ctl_pkg::ADDR_STATUS:
      begin
        r[rst_ctl_pkg::STATUS_VALID_BIT] = valid_q;
        r[rst_ctl_pkg::STATUS_CAUSE_LSB +: 2] = cause_q;
      end
      default:                   r = 8'h00;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Reset pin low-time qualifier
  // ==========================================================
  always_comb
  begin
    lo_cnt_d = 4'h0;
    if (!reset_pin_n)
    begin
      lo_cnt_d = (lo_cnt_q == 4'hF) ? lo_cnt_q : lo_cnt_q + 4'h1;
    end
  end

  assign hw_req = (32'(lo_cnt_d) >= rst_ctl_pkg::HW_MIN_LOW_CYC);

  // ==========================================================
  // Sequencer
  // ==========================================================
  assign wr_ok = reg_req.wr && (st_q == rst_ctl_pkg::ST_READY) && !hw_req;
  assign sw_go = wr_ok && (reg_req.addr == rst_ctl_pkg::ADDR_ICFG0)
                 && reg_req.wdata[rst_ctl_pkg::ICFG0_SOFT_RESET_BIT];

  always_comb
  begin
    st_d       = st_q;
    cause_d    = cause_q;
    tmr_load   = 1'b0;
    tmr_cycles = '0;
    if (!supplies_ok)
    begin
      st_d = rst_ctl_pkg::ST_POR_WAIT;
    end
    else if (hw_req)
    begin
      st_d = rst_ctl_pkg::ST_HW_HOLD;
    end
    else
    begin
      unique case (st_q)
        rst_ctl_pkg::ST_POR_WAIT:
        begin
          // Rails are up: issue the power-on event
          st_d       = rst_ctl_pkg::ST_POR_DLY;
          cause_d    = rst_ctl_pkg::CAUSE_POR;
          tmr_load   = 1'b1;
          tmr_cycles = rst_ctl_pkg::TMR_W'(POR_CYC);
        end
        rst_ctl_pkg::ST_HW_HOLD:
        begin
          st_d       = rst_ctl_pkg::ST_HW_DLY;
          cause_d    = rst_ctl_pkg::CAUSE_HW;
          tmr_load   = 1'b1;
          tmr_cycles = rst_ctl_pkg::TMR_W'(HW_CYC);
        end
        rst_ctl_pkg::ST_POR_DLY,
        rst_ctl_pkg::ST_HW_DLY,
        rst_ctl_pkg::ST_SW_DLY:
        begin
          if (tmr_expired)
          begin
            st_d = rst_ctl_pkg::ST_READY;
          end
        end
        rst_ctl_pkg::ST_READY:
        begin
          if (sw_go)
          begin
            st_d       = rst_ctl_pkg::ST_SW_DLY;
            cause_d    = rst_ctl_pkg::CAUSE_SW;
            tmr_load   = 1'b1;
            tmr_cycles = rst_ctl_pkg::TMR_W'(rst_ctl_pkg::SW_DELAY_CYC);
          end
        end
        default:
        begin
          st_d = rst_ctl_pkg::ST_POR_WAIT;
        end
      endcase
    end
  end

  reset_delay_timer #(
    .W (rst_ctl_pkg::TMR_W)
  ) u_timer (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .load    (tmr_load),
    .cycles  (tmr_cycles),
    .expired (tmr_expired)
  );

  // ==========================================================
  // Register file
  // ==========================================================
  always_comb
  begin
    icfg0_d = icfg0_q;
    icfg1_d = icfg1_q;
    pd_d    = pd_q;
    if (st_d == rst_ctl_pkg::ST_POR_WAIT || st_d == rst_ctl_pkg::ST_HW_HOLD)
    begin
      // Full default load
      icfg0_d = rst_ctl_pkg::ICFG0_RST[6:0];
      icfg1_d = rst_ctl_pkg::ICFG1_RST;
      pd_d    = rst_ctl_pkg::PD_CTRL_RST;
    end
    else if (sw_go)
    begin
      // 0x00 keeps the written bits, 0x01 untouched
      icfg0_d = reg_req.wdata[6:0];
      pd_d    = rst_ctl_pkg::PD_CTRL_RST;
    end
    else if (wr_ok)
    begin
      unique case (reg_req.addr)
        rst_ctl_pkg::ADDR_ICFG0:   icfg0_d = reg_req.wdata[6:0];
        rst_ctl_pkg::ADDR_ICFG1:   icfg1_d = reg_req.wdata;
        rst_ctl_pkg::ADDR_PD_CTRL: pd_d    = reg_req.wdata;
        default:                   pd_d    = pd_q;
      endcase
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_req.rd && st_q == rst_ctl_pkg::ST_READY)
    begin
      rdata_d = read_mux(reg_req.addr);
    end
    valid_d = (st_d == rst_ctl_pkg::ST_READY);
    // Blocks stay off while not ready; power-down bits gate them
    en_d    = valid_d ? pd_d : 8'h00;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q     <= rst_ctl_pkg::ST_POR_WAIT;
      cause_q  <= rst_ctl_pkg::CAUSE_NONE;
      lo_cnt_q <= 4'h0;
      icfg0_q  <= rst_ctl_pkg::ICFG0_RST[6:0];
      icfg1_q  <= rst_ctl_pkg::ICFG1_RST;
      pd_q     <= rst_ctl_pkg::PD_CTRL_RST;
      rdata_q  <= 8'h00;
      valid_q  <= 1'b0;
      en_q     <= 8'h00;
    end
    else
    begin
      st_q     <= st_d;
      cause_q  <= cause_d;
      lo_cnt_q <= lo_cnt_d;
      icfg0_q  <= icfg0_d;
      icfg1_q  <= icfg1_d;
      pd_q     <= pd_d;
      rdata_q  <= rdata_d;
      valid_q  <= valid_d;
      en_q     <= en_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign comm_valid   = valid_q;
  assign block_enable = en_q;

  // ==========================================================
  // Checks
  // ==========================================================
  logic [rst_ctl_pkg::TMR_W-1:0] chk_cnt_q;
  logic                          in_dly;

  assign in_dly = (st_q == rst_ctl_pkg::ST_POR_DLY) || (st_q == rst_ctl_pkg::ST_HW_DLY)
                  || (st_q == rst_ctl_pkg::ST_SW_DLY);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      chk_cnt_q <= '0;
    end
    else
    begin
      chk_cnt_q <= (in_dly && st_d == st_q) ? chk_cnt_q + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  AST_POR_HOLD: assert property (
    !supplies_ok |=> st_q == rst_ctl_pkg::ST_POR_WAIT && !comm_valid)
    else $error("supplies down but sequencer not held");

  AST_POR_DEFAULTS: assert property (
    st_q == rst_ctl_pkg::ST_POR_DLY |-> icfg1_q == rst_ctl_pkg::ICFG1_RST
      && pd_q == rst_ctl_pkg::PD_CTRL_RST && icfg0_q == rst_ctl_pkg::ICFG0_RST[6:0])
    else $error("registers not at default during power-on delay");

  AST_POR_DELAY: assert property (
    st_q == rst_ctl_pkg::ST_POR_DLY && st_d == rst_ctl_pkg::ST_READY
      |-> 32'(chk_cnt_q) == POR_CYC - 1 ##1 comm_valid)
    else $error("power-on delay length wrong");

  AST_PD_AFTER_RESET: assert property (
    $rose(comm_valid) && cause_q != rst_ctl_pkg::CAUSE_SW
      |-> pd_q == rst_ctl_pkg::PD_CTRL_RST && block_enable == rst_ctl_pkg::PD_CTRL_RST)
    else $error("device not in power-down after reset");

  AST_HW_START: assert property (
    supplies_ok && !reset_pin_n |=> st_q == rst_ctl_pkg::ST_HW_HOLD && !comm_valid)
    else $error("reset pin low did not start hardware reset");

  AST_HW_DELAY: assert property (
    st_q == rst_ctl_pkg::ST_HW_DLY && st_d == rst_ctl_pkg::ST_READY
      |-> 32'(chk_cnt_q) == HW_CYC - 1 && pd_q == rst_ctl_pkg::PD_CTRL_RST)
    else $error("hardware reset delay length wrong");

  AST_SW_START: assert property (
    sw_go && supplies_ok |=> st_q == rst_ctl_pkg::ST_SW_DLY && !comm_valid
      && pd_q == rst_ctl_pkg::PD_CTRL_RST)
    else $error("soft reset write did not start software reset");

  AST_SW_KEEP: assert property (
    sw_go && supplies_ok |=> icfg1_q == $past(icfg1_q)
      && icfg0_q == $past(reg_req.wdata[6:0]))
    else $error("soft reset disturbed registers 0x00 or 0x01");

  AST_SW_DELAY: assert property (
    st_q == rst_ctl_pkg::ST_SW_DLY && st_d == rst_ctl_pkg::ST_READY
      |-> 32'(chk_cnt_q) == rst_ctl_pkg::SW_DELAY_CYC - 1)
    else $error("software reset delay length wrong");

  AST_IGNORE_EARLY: assert property (
    in_dly && (reg_req.wr || reg_req.rd) |=> pd_q == $past(pd_q)
      && icfg1_q == $past(icfg1_q) && reg_rdata == 8'h00)
    else $error("access during reset delay had an effect");

  COV_POR_DONE: cover property (st_q == rst_ctl_pkg::ST_POR_DLY ##1 st_q == rst_ctl_pkg::ST_READY);
  COV_HW_DONE:  cover property (st_q == rst_ctl_pkg::ST_HW_DLY ##1 st_q == rst_ctl_pkg::ST_READY);
  COV_SW_DONE:  cover property (sw_go ##1 st_q == rst_ctl_pkg::ST_SW_DLY [*2] ##1 comm_valid);

endmodule

// ==== hdl/rst_ctl_pkg.sv ====
// Shared constants and types for the reset sequencing block
package rst_ctl_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_PERIOD_NS   = 50;
  localparam int POR_DELAY_US    = 250;
  localparam int HW_DELAY_US     = 250;
  localparam int HW_MIN_LOW_NS   = 20;
  localparam int SW_DELAY_NS     = 100;

  // Least times round up, never below one cycle
  function automatic int min_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int POR_DELAY_CYC   = min_cycles(POR_DELAY_US * 1000);
  localparam int HW_DELAY_CYC    = min_cycles(HW_DELAY_US * 1000);
  localparam int HW_MIN_LOW_CYC  = min_cycles(HW_MIN_LOW_NS);
  localparam int SW_DELAY_CYC    = min_cycles(SW_DELAY_NS);
  localparam int TMR_W           = 13;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] ADDR_ICFG0   = 8'h00;
  localparam logic [7:0] ADDR_ICFG1   = 8'h01;
  localparam logic [7:0] ADDR_PD_CTRL = 8'h02;
  localparam logic [7:0] ADDR_STATUS  = 8'h03;

  localparam int         ICFG0_SOFT_RESET_BIT = 7;
  localparam logic [7:0] ICFG0_RST    = 8'h00;
  localparam logic [7:0] ICFG1_RST    = 8'h00;
  localparam logic [7:0] PD_CTRL_RST  = 8'h00;

  localparam int STATUS_VALID_BIT = 0;
  localparam int STATUS_CAUSE_LSB = 1;

  typedef enum logic [1:0] {
    CAUSE_NONE = 2'b00,
    CAUSE_POR  = 2'b01,
    CAUSE_HW   = 2'b10,
    CAUSE_SW   = 2'b11
  } reset_cause_t;

  typedef enum logic [2:0] {
    ST_POR_WAIT = 3'b000,
    ST_POR_DLY  = 3'b001,
    ST_HW_HOLD  = 3'b010,
    ST_HW_DLY   = 3'b011,
    ST_SW_DLY   = 3'b100,
    ST_READY    = 3'b101
  } seq_state_t;

  // ==========================================================
  // Register port carrier
  // ==========================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// ==== hdl/reset_delay_timer.sv ====
// Down counter that times one reset delay
module reset_delay_timer #(
  parameter int W = 13
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] cycles,
  output logic              expired
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // ==========================================================
  // Count
  // ==========================================================
  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
    begin
      cnt_d = cycles - W'(1);
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == '0) && !load;

endmodule

// ==== verification/host_model.sv ====
// Host processor model on the register port and the reset pin
module host_model (
  input  wire logic            clk_sys,
  input  wire logic [7:0]      reg_rdata,
  input  wire logic            comm_valid,
  output rst_ctl_pkg::reg_req_t reg_req,
  output logic                 reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    reg_req = '0;
    reset_pin_n = 1'h1;
  end

  // ==========================================================
  // Bus cycles
  // ==========================================================
  // Released address and data show the inverse of the last value
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clk_sys);
    reg_req <= '{addr: ~a, wdata: ~d, wr: 1'h0, rd: 1'h0};
  endtask

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    put(a, d, 1'h1, 1'h0);
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'h0, 1'h1);
    #1 d = reg_rdata;
  endtask

  // One full cycle low is longer than the least pulse width
  task automatic pulse_reset();
    @(posedge clk_sys);
    reset_pin_n <= 1'h0;
    @(posedge clk_sys);
    reset_pin_n <= 1'h1;
  endtask

  // Holds off traffic until the port reports valid again or 1000 cycles have passed
  task automatic wait_valid(output int n);
    n = 0;
    // Let the edge that launched the last request settle first
    #1;
    while (comm_valid !== 1'h1 && n < 1000)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
endmodule

// ==== verification/device_reset_control_bench.sv ====
// Self-checking bench for the reset sequencer
module device_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int POR_N = 20;
  localparam int HW_N  = 20;

  logic                  clk_sys;
  logic                  nrst;
  logic                  supplies_ok;
  logic                  reset_pin_n;
  rst_ctl_pkg::reg_req_t reg_req;
  logic [7:0]            reg_rdata;
  logic                  comm_valid;
  logic [7:0]            block_enable;
  logic [7:0]            rd_val;
  int                    n_cyc;
  int                    n_errors;
  int                    tests_run;

  initial clk_sys = 1'h0;
  always #25 clk_sys = ~clk_sys;

  device_reset_control #(.POR_CYC(POR_N), .HW_CYC(HW_N)) u_dut (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .supplies_ok  (supplies_ok),
    .reset_pin_n  (reset_pin_n),
    .reg_req      (reg_req),
    .reg_rdata    (reg_rdata),
    .comm_valid   (comm_valid),
    .block_enable (block_enable)
  );

  host_model u_host (
    .clk_sys     (clk_sys),
    .reg_rdata   (reg_rdata),
    .comm_valid  (comm_valid),
    .reg_req     (reg_req),
    .reset_pin_n (reset_pin_n)
  );

  // ==========================================================
  // Compare and verdict
  // ==========================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input int n, input int lo, input int hi);
    chk(8'((n >= lo) && (n <= hi)), 8'h01);
  endtask

  task automatic print_verdict();
    $display("counts: %0d checks, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_por();
    u_host.wait_valid(n_cyc);
    chk_span(n_cyc, POR_N, POR_N + 3);
    chk(block_enable, 8'h00);
    u_host.read(rst_ctl_pkg::ADDR_PD_CTRL, rd_val);
    chk(rd_val, rst_ctl_pkg::PD_CTRL_RST);
    u_host.read(rst_ctl_pkg::ADDR_STATUS, rd_val);
    chk(rd_val, {5'h00, rst_ctl_pkg::CAUSE_POR, 1'h1});
    $display("test por done");
  endtask

  task automatic t_hw();
    u_host.write(rst_ctl_pkg::ADDR_ICFG1, 8'h5A);
    u_host.write(rst_ctl_pkg::ADDR_PD_CTRL, 8'h0F);
    #1 chk(block_enable, 8'h0F);
    u_host.pulse_reset();
    #1 chk({7'h00, comm_valid}, 8'h00);
    chk(block_enable, 8'h00);
    u_host.wait_valid(n_cyc);
    chk_span(n_cyc, HW_N, HW_N + 3);
    u_host.read(rst_ctl_pkg::ADDR_ICFG1, rd_val);
    chk(rd_val, rst_ctl_pkg::ICFG1_RST);
    u_host.read(rst_ctl_pkg::ADDR_STATUS, rd_val);
    chk(rd_val, {5'h00, rst_ctl_pkg::CAUSE_HW, 1'h1});
    $display("test hardware reset done");
  endtask

  task automatic t_early();
    u_host.pulse_reset();
    u_host.write(rst_ctl_pkg::ADDR_PD_CTRL, 8'hFF);
    u_host.write(rst_ctl_pkg::ADDR_ICFG1, 8'h77);
    u_host.read(rst_ctl_pkg::ADDR_PD_CTRL, rd_val);
    chk(rd_val, 8'h00);
    u_host.wait_valid(n_cyc);
    chk(block_enable, 8'h00);
    u_host.read(rst_ctl_pkg::ADDR_ICFG1, rd_val);
    chk(rd_val, rst_ctl_pkg::ICFG1_RST);
    $display("test early access done");
  endtask

  task automatic t_sw();
    u_host.write(rst_ctl_pkg::ADDR_ICFG1, 8'hA5);
    u_host.write(rst_ctl_pkg::ADDR_PD_CTRL, 8'h3C);
    u_host.write(rst_ctl_pkg::ADDR_ICFG0, 8'h95);
    u_host.wait_valid(n_cyc);
    chk_span(n_cyc, rst_ctl_pkg::SW_DELAY_CYC, rst_ctl_pkg::SW_DELAY_CYC + 2);
    u_host.read(rst_ctl_pkg::ADDR_ICFG0, rd_val);
    chk(rd_val, 8'h15);
    u_host.read(rst_ctl_pkg::ADDR_ICFG1, rd_val);
    chk(rd_val, 8'hA5);
    u_host.read(rst_ctl_pkg::ADDR_PD_CTRL, rd_val);
    chk(rd_val, rst_ctl_pkg::PD_CTRL_RST);
    chk(block_enable, 8'h00);
    u_host.write(rst_ctl_pkg::ADDR_STATUS, 8'hFF);
    u_host.read(rst_ctl_pkg::ADDR_STATUS, rd_val);
    chk(rd_val, {5'h00, rst_ctl_pkg::CAUSE_SW, 1'h1});
    @(posedge clk_sys);
    #1 chk(reg_rdata, 8'h00);
    u_host.write(8'h10, 8'hAA);
    u_host.read(8'h10, rd_val);
    chk(rd_val, 8'h00);
    $display("test software reset done");
  endtask

  task automatic t_supply();
    u_host.write(rst_ctl_pkg::ADDR_PD_CTRL, 8'hF0);
    @(posedge clk_sys);
    supplies_ok <= 1'h0;
    repeat (3) @(posedge clk_sys);
    #1 chk({7'h00, comm_valid}, 8'h00);
    chk(block_enable, 8'h00);
    @(posedge clk_sys);
    supplies_ok <= 1'h1;
    u_host.wait_valid(n_cyc);
    chk_span(n_cyc, POR_N, POR_N + 3);
    u_host.read(rst_ctl_pkg::ADDR_PD_CTRL, rd_val);
    chk(rd_val, rst_ctl_pkg::PD_CTRL_RST);
    $display("test supply loss done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial
  begin
    nrst = 1'h0;
    supplies_ok = 1'h1;
    n_errors = 0;
    tests_run = 0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'h1;
    t_por();
    t_hw();
    t_early();
    t_sw();
    t_supply();
    print_verdict();
  end

  initial
  begin
    #(3000 * 50);
    n_errors++;
    print_verdict();
  end
endmodule
